/* core/clk_cfg_pkg.sv */
// Constants, field layout and bus carrier for the clock configuration block
`default_nettype none
package clk_cfg_pkg;

	// ********************************************
	// Register byte offsets
	// ********************************************
	localparam logic [7:0] OFF_MAIN_RATIO = 8'h00;
	localparam logic [7:0] OFF_MAIN_CTL   = 8'h04;
	localparam logic [7:0] OFF_SYS_DIV    = 8'h08;
	localparam logic [7:0] OFF_USB_CTL    = 8'h0C;
	localparam logic [7:0] OFF_USB_RATIO  = 8'h10;
	localparam logic [7:0] OFF_STATUS     = 8'h14;

	// ********************************************
	// Field positions and widths
	// ********************************************
	localparam int MAIN_INT_W      = 7;
	localparam int USB_INT_W       = 6;
	localparam int FRAC_W          = 2;
	localparam int INT_LSB         = 0;
	localparam int FRAC_LSB        = 8;
	localparam int CLK_SEL_BIT     = 0;
	localparam int USB_SRC_BIT     = 0;
	localparam int SYS_DIV_W       = 8;
	localparam int FAIL_BIT        = 0;
	localparam int MAIN_BYP_BIT    = 1;
	localparam int USB_BYP_BIT     = 2;
	localparam int MAIN_RATIO_LSB  = 8;
	localparam int USB_RATIO_LSB   = 20;
	localparam int MAIN_RATIO_W    = MAIN_INT_W + FRAC_W;
	localparam int USB_RATIO_W     = USB_INT_W + FRAC_W;

	// ********************************************
	// Reset values
	// ********************************************
	localparam logic [MAIN_INT_W-1:0] MAIN_INT_RST = 7'h00;
	localparam logic [USB_INT_W-1:0]  USB_INT_RST  = 6'h00;
	localparam logic [FRAC_W-1:0]     FRAC_RST     = 2'h0;
	localparam logic                  CLK_SEL_RST  = 1'b0;
	localparam logic                  USB_SRC_RST  = 1'b0;
	localparam logic [SYS_DIV_W-1:0]  SYS_DIV_RST  = 8'h00;

	// ********************************************
	// Divider and detector counts
	// ********************************************
	localparam logic [7:0] DIV_MAIN_LAST = 8'h01;
	localparam logic [7:0] DIV_USB_LAST  = 8'h03;
	localparam logic [7:0] MISS_LIMIT    = 8'h10;

	// ********************************************
	// AHB-Lite address-phase carrier
	// ********************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} ahb_req_t;

endpackage
`default_nettype wire

/* core/main_and_usb_pll_config.sv */
// Clock path configuration for the main and USB synthesizers
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none

// Functional notes
// R1: Main synthesizer reference is only the primary oscillator tick.
// R2: Main ratio equals integer field plus fractional field.
// R3: Main integer field is seven bits; code n multiplies by n.
// R4: Main integer field zero bypasses to the raw oscillator reference.
// R5: Software keeps main synthesizer output between 150 and 300 MHz.
// R6: Main synthesizer output halved before the bypass mux.
// R7: Bypass mux output divided by the system divider register. The code divides by the register value plus one.
// R8: USB reference mux picks aux clock pin or oscillator by control bit.
// R9: USB ratio is six-bit integer plus fraction; code n multiplies by n.
// R10: Software programs USB synthesizer output to exactly 240 MHz.
// R11: USB synthesizer output divided by four before the USB mux.
// R12: USB integer field zero passes the selected reference directly.
// R13: USB mux output is the USB clock, no further divider.
// R14: Clock select bit picks synthesized path or oscillator for system clock.
// R15: Missing reference substitutes fast internal clock and flags failure.
// R16: Fractions are two-bit quarter steps: 0, 0.25, 0.5, 0.75.
module main_and_usb_pll_config
	import clk_cfg_pkg::*;
(
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_resetn,
	input  wire ahb_req_t                i_ahb,
	input  wire logic [31:0]             i_hwdata,
	output logic      [31:0]             o_hrdata,
	output logic                         o_hreadyout,
	output logic                         o_hresp,
	input  wire logic                    i_osc_tick,
	input  wire logic                    i_aux_tick,
	input  wire logic                    i_fast_osc_tick,
	input  wire logic                    i_main_vco_tick,
	input  wire logic                    i_usb_vco_tick,
	output logic                         o_main_ref_tick,
	output logic      [MAIN_RATIO_W-1:0] o_main_ratio,
	output logic                         o_usb_ref_tick,
	output logic      [USB_RATIO_W-1:0]  o_usb_ratio,
	output logic                         o_main_system_clock,
	output logic                         o_usb_synth_clock,
	output logic                         o_clock_failure_flag
);

	// ********************************************
	// Helpers
	// ********************************************
	// Tick divider step: returns {pulse, next count}
	function automatic logic [8:0] tick_div(input logic [7:0] cnt,
		input logic [7:0] last, input logic tick);
		logic [8:0] r;
		r = {1'b0, cnt};
		if (tick) begin
			if (cnt >= last) begin
				r = {1'b1, 8'h00};
			end else begin
				r = {1'b0, 8'(cnt + 8'h01)};
			end
		end
		return r;
	endfunction

	// ********************************************
	// Register state
	// ********************************************
	logic [MAIN_INT_W-1:0] main_int_mult_q;
	logic [FRAC_W-1:0]     main_frac_mult_q;
	logic                  main_synth_clock_select_q;
	logic [SYS_DIV_W-1:0]  system_clock_divider_q;
	logic                  usb_ref_source_select_q;
	logic [USB_INT_W-1:0]  usb_int_mult_q;
	logic [FRAC_W-1:0]     usb_frac_mult_q;
	logic                  clock_failure_flag_q;

	logic                  wr_pend_q;
	logic [7:0]            wr_addr_q;
	logic                  addr_ok;
	logic [31:0]           rd_data_d;
	logic                  fail_clear;

	logic                  main_bypass;
	logic                  usb_bypass;

	assign main_bypass = (main_int_mult_q == MAIN_INT_RST);  // R4
	assign usb_bypass  = (usb_int_mult_q == USB_INT_RST);    // R12

	// ********************************************
	// AHB-Lite slave
	// ********************************************
	// Zero-wait slave; unmapped addresses read zero and ignore writes
	assign addr_ok = i_ahb.hsel && i_ahb.hready
		&& (i_ahb.htrans == HTRANS_NONSEQ);

	always_comb begin
		rd_data_d = 32'h0000_0000;
		unique case (i_ahb.haddr[7:0])
			OFF_MAIN_RATIO: begin
				rd_data_d[INT_LSB +: MAIN_INT_W] = main_int_mult_q;
				rd_data_d[FRAC_LSB +: FRAC_W]    = main_frac_mult_q;
			end
			OFF_MAIN_CTL: begin
				rd_data_d[CLK_SEL_BIT] = main_synth_clock_select_q;
			end
			OFF_SYS_DIV: begin
				rd_data_d[SYS_DIV_W-1:0] = system_clock_divider_q;
			end
			OFF_USB_CTL: begin
				rd_data_d[USB_SRC_BIT] = usb_ref_source_select_q;
			end
			OFF_USB_RATIO: begin
				rd_data_d[INT_LSB +: USB_INT_W] = usb_int_mult_q;
				rd_data_d[FRAC_LSB +: FRAC_W]   = usb_frac_mult_q;
			end
			OFF_STATUS: begin
				rd_data_d[FAIL_BIT]     = clock_failure_flag_q;
				rd_data_d[MAIN_BYP_BIT] = main_bypass;
				rd_data_d[USB_BYP_BIT]  = usb_bypass;
				rd_data_d[MAIN_RATIO_LSB +: MAIN_RATIO_W] = o_main_ratio;
				rd_data_d[USB_RATIO_LSB +: USB_RATIO_W]   = o_usb_ratio;
			end
			default: begin
				rd_data_d = 32'h0000_0000;
			end
		endcase
		if (i_ahb.haddr[31:8] != 24'h00_0000) begin
			rd_data_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= 8'h00;
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend_q   <= addr_ok && i_ahb.hwrite
				&& (i_ahb.haddr[31:8] == 24'h00_0000);
			wr_addr_q   <= i_ahb.haddr[7:0];
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			if (addr_ok && !i_ahb.hwrite) begin
				o_hrdata <= rd_data_d;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			main_int_mult_q           <= MAIN_INT_RST;
			main_frac_mult_q          <= FRAC_RST;
			main_synth_clock_select_q <= CLK_SEL_RST;
			system_clock_divider_q    <= SYS_DIV_RST;
			usb_ref_source_select_q   <= USB_SRC_RST;
			usb_int_mult_q            <= USB_INT_RST;
			usb_frac_mult_q           <= FRAC_RST;
		end else if (wr_pend_q) begin
			unique case (wr_addr_q)
				OFF_MAIN_RATIO: begin
					main_int_mult_q  <= i_hwdata[INT_LSB +: MAIN_INT_W];  // R3
					main_frac_mult_q <= i_hwdata[FRAC_LSB +: FRAC_W];     // R16
				end
				OFF_MAIN_CTL: begin
					main_synth_clock_select_q <= i_hwdata[CLK_SEL_BIT];
				end
				OFF_SYS_DIV: begin
					system_clock_divider_q <= i_hwdata[SYS_DIV_W-1:0];
				end
				OFF_USB_CTL: begin
					usb_ref_source_select_q <= i_hwdata[USB_SRC_BIT];
				end
				OFF_USB_RATIO: begin
					usb_int_mult_q  <= i_hwdata[INT_LSB +: USB_INT_W];  // R9
					usb_frac_mult_q <= i_hwdata[FRAC_LSB +: FRAC_W];    // R16
				end
				default: begin
				end
			endcase
		end
	end

	assign fail_clear = wr_pend_q && (wr_addr_q == OFF_STATUS)
		&& i_hwdata[FAIL_BIT];

	// ********************************************
	// Ratios to the analog loops, in quarter steps
	// ********************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_main_ratio <= '0;
			o_usb_ratio  <= '0;
		end else begin
			o_main_ratio <= {main_int_mult_q, main_frac_mult_q};  // R2 R16
			o_usb_ratio  <= {usb_int_mult_q, usb_frac_mult_q};    // R9 R16
		end
	end

	// ********************************************
	// Missing reference detector
	// ********************************************
	// Counts fast internal ticks between oscillator ticks
	logic [7:0] miss_cnt_q;
	logic       miss_hit;

	assign miss_hit = i_fast_osc_tick && !i_osc_tick
		&& (miss_cnt_q >= 8'(MISS_LIMIT - 8'h01));

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			miss_cnt_q <= 8'h00;
		end else if (i_osc_tick) begin
			miss_cnt_q <= 8'h00;
		end else if (i_fast_osc_tick && (miss_cnt_q < MISS_LIMIT)) begin
			miss_cnt_q <= 8'(miss_cnt_q + 8'h01);
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			clock_failure_flag_q <= 1'b0;
		end else if (miss_hit) begin
			clock_failure_flag_q <= 1'b1;  // R15
		end else if (fail_clear) begin
			clock_failure_flag_q <= 1'b0;
		end
	end

	// ********************************************
	// Main system clock path
	// ********************************************
	logic [7:0] main_half_cnt_q;
	logic       main_half_tick_q;
	logic [7:0] sys_div_cnt_q;
	logic       sys_tick_q;
	logic [8:0] half_step;
	logic [8:0] sys_step;
	logic       main_mux_tick;
	logic       sys_src_tick;

	assign half_step = tick_div(main_half_cnt_q, DIV_MAIN_LAST,
		i_main_vco_tick);  // R6
	assign main_mux_tick = main_bypass ? i_osc_tick : main_half_tick_q;  // R4
	assign sys_src_tick  = main_synth_clock_select_q ? main_mux_tick
		: i_osc_tick;  // R14
	assign sys_step = tick_div(sys_div_cnt_q, system_clock_divider_q,
		sys_src_tick);  // R7

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			main_half_cnt_q  <= 8'h00;
			main_half_tick_q <= 1'b0;
			sys_div_cnt_q    <= 8'h00;
			sys_tick_q       <= 1'b0;
		end else begin
			main_half_cnt_q  <= half_step[7:0];
			main_half_tick_q <= half_step[8];
			sys_div_cnt_q    <= sys_step[7:0];
			sys_tick_q       <= sys_step[8];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_main_ref_tick      <= 1'b0;
			o_main_system_clock  <= 1'b0;
			o_clock_failure_flag <= 1'b0;
		end else begin
			o_main_ref_tick      <= i_osc_tick;  // R1
			o_clock_failure_flag <= clock_failure_flag_q;
			// Fast clock bypasses the divider while the failure flag is set, until software clears it
			o_main_system_clock  <= clock_failure_flag_q ? i_fast_osc_tick
				: sys_tick_q;  // R15
		end
	end

	// ********************************************
	// USB clock path
	// ********************************************
	logic [7:0] usb_quarter_cnt_q;
	logic       usb_quarter_tick_q;
	logic       usb_ref_sel_tick;
	logic [8:0] quarter_step;

	assign usb_ref_sel_tick = usb_ref_source_select_q ? i_aux_tick
		: i_osc_tick;  // R8
	assign quarter_step = tick_div(usb_quarter_cnt_q, DIV_USB_LAST,
		i_usb_vco_tick);  // R11

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			usb_quarter_cnt_q  <= 8'h00;
			usb_quarter_tick_q <= 1'b0;
			o_usb_ref_tick     <= 1'b0;
			o_usb_synth_clock  <= 1'b0;
		end else begin
			usb_quarter_cnt_q  <= quarter_step[7:0];
			usb_quarter_tick_q <= quarter_step[8];
			o_usb_ref_tick     <= usb_ref_sel_tick;
			// No divider after this mux
			o_usb_synth_clock  <= usb_bypass ? usb_ref_sel_tick
				: usb_quarter_tick_q;  // R12 R13
		end
	end

endmodule // main_and_usb_pll_config
`default_nettype wire

/* tb/main_and_usb_pll_config_test.sv */
// Self-checking bench for the clock configuration block
`default_nettype none
module main_and_usb_pll_config_test import clk_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_ref_clk = 1'b0, i_resetn = 1'b0, osc_on = 1'b1, rd_ph = 1'b0;
	logic        i_osc_tick = 1'b0, i_aux_tick = 1'b0, i_fast_osc_tick = 1'b0;
	logic        i_main_vco_tick = 1'b0, i_usb_vco_tick = 1'b0;
	logic [31:0] i_hwdata = 32'h0, o_hrdata, exp_q[$];
	ahb_req_t    req = '0, i_ahb;
	logic [8:0]  o_main_ratio;
	logic [7:0]  o_usb_ratio;
	logic        o_hreadyout, o_hresp, o_main_ref_tick, o_usb_ref_tick;
	logic        o_main_system_clock, o_usb_synth_clock, o_clock_failure_flag;
	int          fails = 0, comparisons = 0, seed = 48617, cyc = 0;
	int          sys_last = 0, sys_gap = 0, usb_last = 0, usb_gap = 0;
	assign i_ahb = {req[39:1], o_hreadyout};
	main_and_usb_pll_config DUT (.i_ref_clk, .i_resetn, .i_ahb, .i_hwdata,
		.o_hrdata, .o_hreadyout, .o_hresp, .i_osc_tick, .i_aux_tick,
		.i_fast_osc_tick, .i_main_vco_tick, .i_usb_vco_tick, .o_main_ref_tick,
		.o_main_ratio, .o_usb_ref_tick, .o_usb_ratio, .o_main_system_clock,
		.o_usb_synth_clock, .o_clock_failure_flag);
	initial forever #20 i_ref_clk = ~i_ref_clk;
	// ********************************************
	// Tick sources and pulse spacing monitor
	// ********************************************
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		i_osc_tick <= osc_on && cyc % 4 == 0;
		i_aux_tick <= cyc % 3 == 0;
		i_fast_osc_tick <= cyc % 5 == 0;
		i_main_vco_tick <= 1'b1;
		i_usb_vco_tick <= cyc % 2 == 0;
		if (o_main_system_clock === 1'b1) begin
			sys_gap <= cyc - sys_last;
			sys_last <= cyc;
		end
		if (o_usb_synth_clock === 1'b1) begin
			usb_gap <= cyc - usb_last;
			usb_last <= cyc;
		end
		if (rd_ph && o_hreadyout === 1'b1)
			check(o_hrdata, exp_q.pop_front());
	end
	function automatic void check(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endfunction
	function automatic logic [31:0] stat(logic [8:0] m, logic [7:0] u, logic f);
		return {4'h0, u, 3'h0, m, 5'h0, u[7:2] == 6'h0, m[8:2] == 7'h0, f};
	endfunction
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait: a stuck slave ends the run as a mismatch
	task automatic wait_rdy();
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge i_ref_clk);
			if (o_hreadyout === 1'b1)
				break;
		end
		if (n == 50) begin
			fails++;
			close_out();
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		req <= '{1'b1, {24'h0, a}, HTRANS_NONSEQ, w, 3'h2, 1'b1};
		wait_rdy();
		req.hsel <= 1'b0;
		req.htrans <= 2'h0;
		i_hwdata <= d;
		rd_ph <= !w;
		wait_rdy();
		rd_ph <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// ********************************************
	// Main sequence
	// ********************************************
	initial begin
		logic [31:0] d;
		logic [8:0]  m;
		logic [7:0]  u;
		logic [31:0] mask [5] = '{32'h37F, 32'h1, 32'hFF, 32'h1, 32'h33F};
		logic [31:0] cfg [3][5] = '{'{32'h000, 32'h1, 32'h2, 32'h0, 32'h000},
			'{32'h205, 32'h1, 32'h1, 32'h1, 32'h006},
			'{32'h005, 32'h0, 32'h0, 32'h1, 32'h000}};
		int gap [3][2] = '{'{12, 4}, '{4, 8}, '{4, 3}};
		repeat (20) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		@(posedge i_ref_clk);
		for (int i = 0; i < 7; i++)
			rd(8'(i * 4), i == 5 ? stat(9'h0, 8'h0, 1'b0) : 32'h0);
		for (int i = 0; i < 5; i++) begin
			d = $random(seed);
			bus(1'b1, 8'(i * 4), d);
			rd(8'(i * 4), d & mask[i]);
		end
		bus(1'b1, 8'h18, 32'hFFFFFFFF);
		rd(8'h18, 32'h0);
		for (int c = 0; c < 3; c++) begin
			for (int i = 0; i < 5; i++)
				bus(1'b1, 8'(i * 4), cfg[c][i]);
			m = {cfg[c][0][6:0], cfg[c][0][9:8]};
			u = {cfg[c][4][5:0], cfg[c][4][9:8]};
			repeat (60) @(posedge i_ref_clk);
			check(32'(sys_gap), 32'(gap[c][0]));
			check(32'(usb_gap), 32'(gap[c][1]));
			check(32'({o_main_ratio, o_usb_ratio}), {m, u});
			rd(8'h14, stat(m, u, 1'b0));
		end
		osc_on <= 1'b0;
		for (int n = 0; n < 200; n++) begin
			@(posedge i_ref_clk);
			if (o_clock_failure_flag === 1'b1)
				break;
		end
		// A flag that never comes within 200 cycles ends the run as a failure
		if (o_clock_failure_flag !== 1'b1) begin
			fails++;
			close_out();
		end
		repeat (20) @(posedge i_ref_clk);
		check(32'(sys_gap), 32'h5);
		rd(8'h14, stat(m, u, 1'b1));
		osc_on <= 1'b1;
		repeat (8) @(posedge i_ref_clk);
		bus(1'b1, 8'h14, 32'h1);
		rd(8'h14, stat(m, u, 1'b0));
		@(posedge i_ref_clk);
		close_out();
	end
endmodule // main_and_usb_pll_config_test
`default_nettype wire

/* tb/pll_cfg_checker.sv */
// Port-level assertions for the clock configuration block
`default_nettype none
module pll_cfg_checker
	import clk_cfg_pkg::*;
(
	input wire logic                    i_ref_clk,
	input wire logic                    i_resetn,
	input wire ahb_req_t                i_ahb,
	input wire logic                    i_osc_tick,
	input wire logic                    i_aux_tick,
	input wire logic                    i_fast_osc_tick,
	input wire logic                    i_usb_vco_tick,
	input wire logic                    o_hreadyout,
	input wire logic                    o_hresp,
	input wire logic                    o_main_ref_tick,
	input wire logic [MAIN_RATIO_W-1:0] o_main_ratio,
	input wire logic                    o_usb_ref_tick,
	input wire logic [USB_RATIO_W-1:0]  o_usb_ratio,
	input wire logic                    o_main_system_clock,
	input wire logic                    o_usb_synth_clock,
	input wire logic                    o_clock_failure_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	logic [7:0] miss_q;
	logic       wr_a;
	assign wr_a = i_ahb.hsel && i_ahb.hwrite && i_ahb.htrans == HTRANS_NONSEQ;
	// Saturates so a long outage cannot wrap into a false second event
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn || i_osc_tick)
			miss_q <= 8'h00;
		else if (i_fast_osc_tick && miss_q != 8'hFF)
			miss_q <= miss_q + 8'h01;
	end
	sequence s_miss16;
		miss_q == 8'h10 && $past(miss_q) == 8'h0F;
	endsequence
	sequence s_usb_byp;
		(o_usb_ratio[7:2] == 6'h00) [*3];
	endsequence
	sequence s_usb_run;
		(o_usb_ratio[7:2] != 6'h00) [*3];
	endsequence
	AST_REF_TICK: assert property (
		1'b1 |=> o_main_ref_tick == $past(i_osc_tick))
		else $error("main reference tick not the oscillator tick");
	AST_USB_REF: assert property (
		o_usb_ref_tick |-> $past(i_osc_tick) || $past(i_aux_tick))
		else $error("usb reference tick from no source");
	AST_USB_BYPASS: assert property (
		s_usb_byp |-> o_usb_synth_clock == o_usb_ref_tick)
		else $error("usb bypass clock differs from reference");
	AST_USB_DIV: assert property (
		s_usb_run |-> !o_usb_synth_clock || $past(i_usb_vco_tick, 2))
		else $error("usb clock pulse without synthesizer tick");
	AST_FAIL_SET: assert property (
		s_miss16 |-> ##[0:2] o_clock_failure_flag)
		else $error("missing reference not flagged");
	AST_FAIL_SUBST: assert property (
		o_clock_failure_flag && $past(o_clock_failure_flag)
		|-> o_main_system_clock == $past(i_fast_osc_tick))
		else $error("system clock not substituted");
	// Field lands two cycles after the address, the ratio port one later
	AST_RATIO_WRITE: assert property (
		!$stable(o_main_ratio) || !$stable(o_usb_ratio)
		|-> $past(wr_a, 3))
		else $error("ratio changed without a write");
	AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
		else $error("bus not ready or not okay");
endmodule // pll_cfg_checker
bind main_and_usb_pll_config pll_cfg_checker chk (.i_ref_clk, .i_resetn,
	.i_ahb, .i_osc_tick, .i_aux_tick, .i_fast_osc_tick, .i_usb_vco_tick,
	.o_hreadyout, .o_hresp, .o_main_ref_tick, .o_main_ratio,
	.o_usb_ref_tick, .o_usb_ratio, .o_main_system_clock,
	.o_usb_synth_clock, .o_clock_failure_flag);
`default_nettype wire
